// [core/asc_ctrl.sv]
`default_nettype none
//
// Function
// - Inactivity count sets minimum time before sleep
// - Step 320 ms, or 640 ms at 1.56 Hz
// - Enabled function events restart timer; others do not
// - Wake needs interrupt enable and wake source
// - Enabled functions keep running at sleep rate
// - Auto sleep off: only standby and wake
// - Sleep entry and exit to wake raise enabled event
// - Sleep rate field bits 7:6 select rate
// - Sleep rate overrides all rates while asleep
// - Data rate field bits 5:3 select rate
// - Bit 0 selects standby or active
// - Low noise limits range to 4g
// - Fast read skips low data bytes
// - Control two field layout
// - Self test enable shifts axis outputs
// - Soft reset reloads defaults, resets serial port
// - Soft reset self-clears, always reads zero
// - Oversampling scheme per wake and sleep
// - Averaging ratio from scheme and rate
// - Wake source bit one lets function wake
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          reg_wr_en,
  input  wire logic          reg_rd_en,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output var  logic [7:0]    reg_rdata,
  output var  logic          reg_rvalid,
  input  wire asc_evt_type   evt,
  output var  asc_state_type mode_state,
  output var  logic [2:0]    cur_rate_sel,
  output var  logic [1:0]    cur_os_mode,
  output var  logic [10:0]   cur_os_ratio,
  output var  logic          sample_tick,
  output var  logic [3:0]    func_enable,
  output var  logic          range_limit_4g,
  output var  logic          fast_read_en,
  output var  logic          self_test_en,
  output var  logic          sleep_wake_irq,
  output var  logic          serial_if_rst,
  output var  logic          boot_busy
);

  asc_sc1_type   sc1_r;
  asc_sc2_type   sc2_r;
  logic [7:0]    inact_count_r;
  logic [7:0]    wake_src_r;
  logic [7:0]    irq_en_r;
  asc_state_type state_r;
  asc_state_type state_nxt;
  logic [4:0]    boot_cnt_r;
  logic [9:0]    tick_cnt_r;
  logic [7:0]    step_cnt_r;
  logic          base_tick;
  logic          booting;
  logic          soft_rst_req;
  logic [3:0]    fn_evt;
  logic [3:0]    fn_irq_en;
  logic [3:0]    fn_wake_src;
  logic          restart_hit;
  logic          wake_hit;
  logic [9:0]    step_ticks;
  logic [2:0]    rate_nxt;
  logic [1:0]    os_nxt;

  // ----------------------------------------------------------------
  // Function helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] os_ratio(input logic [1:0] mode, input logic [2:0] rate);
    logic [10:0] r;
    r = 11'h002;
    case (mode)
      OS_NORMAL: begin
        case (rate)
          3'h0:    r = 11'h002;
          3'h5:    r = 11'h010;
          3'h6:    r = 11'h020;
          3'h7:    r = 11'h080;
          default: r = 11'h004;
        endcase
      end
      OS_LNLP: begin
        case (rate)
          3'h0:    r = 11'h002;
          3'h6:    r = 11'h008;
          3'h7:    r = 11'h020;
          default: r = 11'h004;
        endcase
      end
      OS_HIRES: begin
        case (rate)
          3'h0:    r = 11'h002;
          3'h1:    r = 11'h004;
          3'h2:    r = 11'h008;
          3'h3:    r = 11'h010;
          3'h4:    r = 11'h020;
          3'h5:    r = 11'h080;
          3'h6:    r = 11'h100;
          default: r = 11'h400;
        endcase
      end
      default: begin
        case (rate)
          3'h6:    r = 11'h004;
          3'h7:    r = 11'h010;
          default: r = 11'h002;
        endcase
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Event steering
  // ----------------------------------------------------------------
  // Sleep/wake and data-ready events take no part in the timer or wake
  assign fn_evt      = {evt.transient_event, evt.orientation_event,
                        evt.pulse_event, evt.freefall_motion_event};
  assign fn_irq_en   = {irq_en_r[IE_TRANS_BIT], irq_en_r[IE_ORIENT_BIT],
                        irq_en_r[IE_PULSE_BIT], irq_en_r[IE_FFMT_BIT]};
  assign fn_wake_src = {wake_src_r[WS_TRANS_BIT], wake_src_r[WS_ORIENT_BIT],
                        wake_src_r[WS_PULSE_BIT], wake_src_r[WS_FFMT_BIT]};
  assign restart_hit = |(fn_evt & fn_irq_en);
  assign wake_hit    = |(fn_evt & fn_irq_en & fn_wake_src);

  // ----------------------------------------------------------------
  // Soft reset and boot
  // ----------------------------------------------------------------
  assign booting      = (boot_cnt_r != 5'h00);
  assign soft_rst_req = reg_wr_en && !booting && (reg_addr == OFF_SC2)
                        && reg_wdata[SC2_SOFT_RST_BIT];

  // Effective immediately in any state; boot holds everything at default
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_cnt_r <= 5'h00;
    end else if (soft_rst_req) begin
      boot_cnt_r <= BOOT_CYC;
    end else if (booting) begin
      boot_cnt_r <= boot_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_if_rst <= 1'b0;
      boot_busy     <= 1'b0;
    end else begin
      serial_if_rst <= soft_rst_req || (boot_cnt_r > 5'h01);
      boot_busy     <= soft_rst_req || (boot_cnt_r > 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sc1_r <= asc_sc1_type'(RST_SC1);
    end else if (soft_rst_req || booting) begin
      sc1_r <= asc_sc1_type'(RST_SC1);
    end else if (reg_wr_en && reg_addr == OFF_SC1) begin
      if (sc1_r.active) begin
        // Other fields are frozen while active; standby is always reachable
        sc1_r.active <= reg_wdata[0];
      end else begin
        sc1_r <= asc_sc1_type'(reg_wdata);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sc2_r <= asc_sc2_type'(RST_SC2);
    end else if (soft_rst_req || booting) begin
      sc2_r <= asc_sc2_type'(RST_SC2);
    end else if (reg_wr_en && reg_addr == OFF_SC2) begin
      sc2_r <= asc_sc2_type'(reg_wdata & SC2_WR_MASK);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inact_count_r <= RST_INACT;
      wake_src_r    <= RST_WAKE_SRC;
      irq_en_r      <= RST_IRQ_EN;
    end else if (soft_rst_req || booting) begin
      inact_count_r <= RST_INACT;
      wake_src_r    <= RST_WAKE_SRC;
      irq_en_r      <= RST_IRQ_EN;
    end else if (reg_wr_en) begin
      if (reg_addr == OFF_INACT) begin
        inact_count_r <= reg_wdata;
      end
      if (reg_addr == OFF_WAKE_SRC) begin
        wake_src_r <= reg_wdata & WAKE_SRC_MASK;
      end
      if (reg_addr == OFF_IRQ_EN) begin
        irq_en_r <= reg_wdata & IRQ_EN_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd_en && !booting;
      if (reg_rd_en && !booting) begin
        case (reg_addr)
          OFF_INACT:    reg_rdata <= inact_count_r;
          OFF_SC1:      reg_rdata <= sc1_r;
          OFF_SC2:      reg_rdata <= sc2_r & SC2_WR_MASK & ~(8'h01 << SC2_SOFT_RST_BIT);
          OFF_WAKE_SRC: reg_rdata <= wake_src_r;
          OFF_IRQ_EN:   reg_rdata <= irq_en_r;
          default:      reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Inactivity timer
  // ----------------------------------------------------------------
  // Step length follows the wake rate, not the sleep rate
  assign step_ticks = (sc1_r.data_rate_sel == RATE_1P56) ? INACT_SLOW_TICKS
                                                         : INACT_STEP_TICKS;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 10'h000;
      step_cnt_r <= 8'h00;
    end else if (state_r != ST_WAKE || !sc2_r.auto_sleep_en || restart_hit || booting) begin
      tick_cnt_r <= 10'h000;
      step_cnt_r <= 8'h00;
    end else if (base_tick) begin
      if (tick_cnt_r + 10'h001 >= step_ticks) begin
        tick_cnt_r <= 10'h000;
        if (step_cnt_r != 8'hff) begin
          step_cnt_r <= step_cnt_r + 1'b1;
        end
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STANDBY: begin
        if (sc1_r.active) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!sc1_r.active) begin
          state_nxt = ST_STANDBY;
        end else if (sc2_r.auto_sleep_en && !restart_hit
                     && step_cnt_r >= inact_count_r) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!sc1_r.active) begin
          state_nxt = ST_STANDBY;
        end else if (wake_hit || !sc2_r.auto_sleep_en) begin
          state_nxt = ST_WAKE;
        end
      end
      default: state_nxt = ST_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_STANDBY;
    end else if (booting) begin
      state_r <= ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pulse on each automatic entry to or exit from sleep
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sleep_wake_irq <= 1'b0;
    end else begin
      sleep_wake_irq <= !booting && irq_en_r[IE_ASLP_BIT]
                        && ((state_r == ST_WAKE && state_nxt == ST_SLEEP)
                         || (state_r == ST_SLEEP && state_nxt == ST_WAKE));
    end
  end

  // ----------------------------------------------------------------
  // Rate and oversampling outputs
  // ----------------------------------------------------------------
  assign rate_nxt = (state_nxt == ST_SLEEP) ? sleep_rate_code(sc1_r.sleep_rate_sel)
                                            : sc1_r.data_rate_sel;
  assign os_nxt   = (state_nxt == ST_SLEEP) ? sc2_r.sleep_os_mode
                                            : sc2_r.wake_os_mode;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_rate_sel <= RATE_800;
      cur_os_mode  <= OS_NORMAL;
      cur_os_ratio <= 11'h002;
      mode_state   <= ST_STANDBY;
      func_enable  <= 4'h0;
    end else begin
      cur_rate_sel <= rate_nxt;
      cur_os_mode  <= os_nxt;
      cur_os_ratio <= os_ratio(os_nxt, rate_nxt);
      mode_state   <= booting ? ST_STANDBY : state_nxt;
      // Enabled functions keep running in sleep, at the sleep rate
      func_enable  <= (!booting && state_nxt != ST_STANDBY) ? fn_irq_en : 4'h0;
    end
  end

  // Range limit makes thresholds above 4g unreachable downstream
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      range_limit_4g <= 1'b0;
      fast_read_en   <= 1'b0;
      self_test_en   <= 1'b0;
    end else begin
      range_limit_4g <= sc1_r.low_noise_sel;
      fast_read_en   <= sc1_r.fast_read_sel;
      self_test_en   <= sc2_r.self_test_en;
    end
  end

  // ----------------------------------------------------------------
  // Sample timebase
  // ----------------------------------------------------------------
  asc_rate_gen #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_rate_gen (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .clr         (booting),
    .rate_sel    (cur_rate_sel),
    .base_tick   (base_tick),
    .sample_tick (sample_tick)
  );

endmodule
`default_nettype wire

// [core/asc_pkg.sv]
`default_nettype none
package asc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_INACT       = 8'h29;
  localparam logic [7:0]  OFF_SC1         = 8'h2a;
  localparam logic [7:0]  OFF_SC2         = 8'h2b;
  localparam logic [7:0]  OFF_WAKE_SRC    = 8'h2c;
  localparam logic [7:0]  OFF_IRQ_EN      = 8'h2d;

  localparam logic [7:0]  RST_INACT       = 8'h00;
  localparam logic [7:0]  RST_SC1         = 8'h00;
  localparam logic [7:0]  RST_SC2         = 8'h00;
  localparam logic [7:0]  RST_WAKE_SRC    = 8'h00;
  localparam logic [7:0]  RST_IRQ_EN      = 8'h00;

  // Writable bits; the rest read as zero
  localparam logic [7:0]  SC2_WR_MASK     = 8'h9f;
  localparam logic [7:0]  WAKE_SRC_MASK   = 8'h7b;
  localparam logic [7:0]  IRQ_EN_MASK     = 8'hbd;

  localparam int          SC2_SOFT_RST_BIT = 6;
  localparam int          WS_TRANS_BIT    = 6;
  localparam int          WS_ORIENT_BIT   = 5;
  localparam int          WS_PULSE_BIT    = 4;
  localparam int          WS_FFMT_BIT     = 3;
  localparam int          IE_ASLP_BIT     = 7;
  localparam int          IE_TRANS_BIT    = 5;
  localparam int          IE_ORIENT_BIT   = 4;
  localparam int          IE_PULSE_BIT    = 3;
  localparam int          IE_FFMT_BIT     = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          SYS_CLK_PERIOD_NS  = 40;
  localparam int          BASE_STEP_NS       = 1250000;
  localparam int          BASE_CYC           = BASE_STEP_NS / SYS_CLK_PERIOD_NS;
  localparam int          INACT_STEP_MS      = 320;
  localparam int          INACT_STEP_SLOW_MS = 640;
  localparam logic [9:0]  INACT_STEP_TICKS   = 10'(INACT_STEP_MS * 1000000 / BASE_STEP_NS);
  localparam logic [9:0]  INACT_SLOW_TICKS   = 10'(INACT_STEP_SLOW_MS * 1000000 / BASE_STEP_NS);
  localparam logic [4:0]  BOOT_CYC           = 5'h10;
  localparam int          BASE_CNT_W         = 16;

  // ----------------------------------------------------------------
  // Rates and oversampling schemes
  // ----------------------------------------------------------------
  localparam logic [2:0]  RATE_800        = 3'h0;
  localparam logic [2:0]  RATE_1P56       = 3'h7;
  localparam logic [1:0]  OS_NORMAL       = 2'h0;
  localparam logic [1:0]  OS_LNLP         = 2'h1;
  localparam logic [1:0]  OS_HIRES        = 2'h2;
  localparam logic [1:0]  OS_LP           = 2'h3;

  typedef enum logic [1:0] {ST_STANDBY, ST_WAKE, ST_SLEEP} asc_state_type;

  typedef struct packed {
    logic [1:0] sleep_rate_sel;
    logic [2:0] data_rate_sel;
    logic       low_noise_sel;
    logic       fast_read_sel;
    logic       active;
  } asc_sc1_type;

  typedef struct packed {
    logic       self_test_en;
    logic       soft_reset;
    logic       zero;
    logic [1:0] sleep_os_mode;
    logic       auto_sleep_en;
    logic [1:0] wake_os_mode;
  } asc_sc2_type;

  typedef struct packed {
    logic transient_event;
    logic orientation_event;
    logic pulse_event;
    logic freefall_motion_event;
    logic sleep_wake_event;
    logic data_ready_event;
  } asc_evt_type;

  // Sleep codes map onto the four slowest wake codes
  function automatic logic [2:0] sleep_rate_code(input logic [1:0] sel);
    return {1'b1, sel};
  endfunction

  // Base ticks per sample, minus one
  function automatic logic [8:0] rate_mask(input logic [2:0] rate);
    case (rate)
      3'h0:    return 9'h000;
      3'h1:    return 9'h001;
      3'h2:    return 9'h003;
      3'h3:    return 9'h007;
      3'h4:    return 9'h00f;
      3'h5:    return 9'h03f;
      3'h6:    return 9'h07f;
      default: return 9'h1ff;
    endcase
  endfunction

endpackage
`default_nettype wire

// [core/asc_rate_gen.sv]
`default_nettype none
module asc_rate_gen
  import asc_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic [2:0] rate_sel,
  output var  logic       base_tick,
  output var  logic       sample_tick
);

  logic [BASE_CNT_W-1:0] base_cnt_r;
  logic [8:0]            sub_cnt_r;

  // ----------------------------------------------------------------
  // 1.25 ms timebase
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      base_cnt_r <= '0;
      base_tick  <= 1'b0;
    end else if (clr) begin
      base_cnt_r <= '0;
      base_tick  <= 1'b0;
    end else if (base_cnt_r == BASE_CNT_W'(BASE_CYCLES - 1)) begin
      base_cnt_r <= '0;
      base_tick  <= 1'b1;
    end else begin
      base_cnt_r <= base_cnt_r + 1'b1;
      base_tick  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sample strobe
  // ----------------------------------------------------------------
  // Free-running sub count keeps a rate change aligned to the next sample
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sub_cnt_r   <= '0;
      sample_tick <= 1'b0;
    end else if (clr) begin
      sub_cnt_r   <= '0;
      sample_tick <= 1'b0;
    end else begin
      if (base_tick) begin
        sub_cnt_r <= sub_cnt_r + 1'b1;
      end
      sample_tick <= base_tick && ((sub_cnt_r & rate_mask(rate_sel)) == rate_mask(rate_sel));
    end
  end

endmodule
`default_nettype wire

// [dv/asc_ctrl_properties.sv]
`default_nettype none
module asc_ctrl_checker
  import asc_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYC
) (
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic          reg_wr_en,
  input wire logic          reg_rd_en,
  input wire logic [7:0]    reg_addr,
  input wire logic [7:0]    reg_wdata,
  input wire logic [7:0]    reg_rdata,
  input wire logic          reg_rvalid,
  input wire asc_evt_type   evt,
  input wire asc_state_type mode_state,
  input wire logic [2:0]    cur_rate_sel,
  input wire logic [10:0]   cur_os_ratio,
  input wire logic          range_limit_4g,
  input wire logic          fast_read_en,
  input wire logic          sleep_wake_irq,
  input wire logic          serial_if_rst,
  input wire logic          boot_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ok;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Writes during boot are dropped, so only live writes count
  assign wr_ok = reg_wr_en && !boot_busy;

  sc2_read_zero_a: assert property (
    reg_rvalid && $past(reg_rd_en && reg_addr == OFF_SC2) |-> reg_rdata[6:5] == 2'h0)
    else $error("control two reads back reset or zero bit set");
  soft_reset_boot_a: assert property (
    wr_ok && reg_addr == OFF_SC2 && reg_wdata[6]
    |-> ##2 (serial_if_rst && boot_busy && mode_state == ST_STANDBY))
    else $error("soft reset did not restart the device");
  standby_select_a: assert property (
    wr_ok && reg_addr == OFF_SC1 && !reg_wdata[0] |-> ##2 mode_state == ST_STANDBY)
    else $error("active bit cleared but not in standby");
  sleep_from_wake_a: assert property (
    mode_state == ST_SLEEP && $past(mode_state) != ST_SLEEP |-> $past(mode_state) == ST_WAKE)
    else $error("sleep entered from a state other than wake");
  sleep_rate_a: assert property (
    mode_state == ST_SLEEP |-> cur_rate_sel[2])
    else $error("sleep state runs at a wake only rate");
  irq_on_change_a: assert property (
    sleep_wake_irq |-> $changed(mode_state))
    else $error("sleep wake event without a state change");
  no_false_wake_a: assert property (
    mode_state == ST_SLEEP && !$past(reg_wr_en) && evt[5:2] == 4'h0 |=> mode_state != ST_WAKE)
    else $error("woke without a function event");
  sc1_copy_a: assert property (
    wr_ok && reg_addr == OFF_SC1 && mode_state == ST_STANDBY
    |-> ##2 (range_limit_4g == $past(reg_wdata[2], 2) && fast_read_en == $past(reg_wdata[1], 2)))
    else $error("range or fast read copy wrong");
  ratio_fast_a: assert property (
    cur_rate_sel == RATE_800 |-> cur_os_ratio == 11'h002)
    else $error("averaging ratio wrong at fastest rate");
endmodule

bind asc_ctrl asc_ctrl_checker #(.BASE_CYCLES(BASE_CYCLES)) u_checker (.*);
`default_nettype wire

// [dv/asc_host_model.sv]
`default_nettype none
module asc_host_model (
  input  wire logic       sys_clk,
  output var  logic       reg_wr_en,
  output var  logic       reg_rd_en,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Idle bus shows inverted values so stale data never looks valid
  task automatic release_bus();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    release_bus();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    // Answer stands for one cycle only, so take it before letting go
    @(negedge sys_clk);
    ok = reg_rvalid;
    d  = reg_rdata;
    release_bus();
  endtask
endmodule
`default_nettype wire

// [dv/test_auto_sleep_mode_control.sv]
`default_nettype none
module test_auto_sleep_mode_control;
  import asc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic          reg_wr_en, reg_rd_en, reg_rvalid, sample_tick;
  logic [7:0]    reg_addr, reg_wdata, reg_rdata;
  asc_evt_type   evt = '0;
  asc_state_type mode_state;
  logic [2:0]    cur_rate_sel;
  logic [1:0]    cur_os_mode;
  logic [10:0]   cur_os_ratio;
  logic [3:0]    func_enable;
  logic          range_limit_4g, fast_read_en, self_test_en;
  logic          sleep_wake_irq, serial_if_rst, boot_busy;
  int            num_errors = 0;
  int            checks = 0;
  int            cycles = 0;
  int            irq_cnt = 0;
  int            ticks = 0;

  // Small base period keeps a 256 tick step at 1024 cycles
  asc_ctrl #(.BASE_CYCLES(4)) u_dut (.*);
  asc_host_model u_host (.*);

  always #20 sys_clk = ~sys_clk;

  always @(negedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // Counted at the rising edge so no check at a falling edge races the count
  always @(posedge sys_clk) begin
    if (sleep_wake_irq === 1'b1) irq_cnt++;
    if (sample_tick === 1'b1) ticks++;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.rd(a, d, ok);
    chk({2'h0, ok, d}, {3'h1, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wait_mode(input asc_state_type s, input int lim);
    for (int i = 0; i < lim && mode_state !== s; i++) @(negedge sys_clk);
    chk(11'(mode_state), 11'(s));
  endtask

  task automatic pulse(input asc_evt_type e);
    @(negedge sys_clk);
    evt = e;
    @(negedge sys_clk);
    evt = '0;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    idle(8);
    rst = 1'b0;
    rd_chk(OFF_INACT, RST_INACT);
    rd_chk(OFF_SC1, RST_SC1);
    rd_chk(OFF_SC2, RST_SC2);
    rd_chk(OFF_WAKE_SRC, RST_WAKE_SRC);
    rd_chk(OFF_IRQ_EN, RST_IRQ_EN);
    rd_chk(8'h30, 8'h00);
    u_host.wr(OFF_WAKE_SRC, 8'hff);
    rd_chk(OFF_WAKE_SRC, WAKE_SRC_MASK);
    u_host.wr(OFF_IRQ_EN, 8'hff);
    rd_chk(OFF_IRQ_EN, IRQ_EN_MASK);
    u_host.wr(OFF_INACT, 8'h02);
    u_host.wr(OFF_SC2, 8'hae);
    rd_chk(OFF_SC2, 8'h8e);
    chk(11'(self_test_en), 11'h001);
    u_host.wr(OFF_SC1, 8'h56);
    rd_chk(OFF_SC1, 8'h56);
    chk(11'({range_limit_4g, fast_read_en}), 11'h003);
    u_host.wr(OFF_SC1, 8'h57);
    wait_mode(ST_WAKE, 4);
    chk(11'(cur_rate_sel), 11'h002);
    chk(11'(cur_os_mode), 11'h002);
    // Field change while active is ignored
    u_host.wr(OFF_SC1, 8'hf9);
    rd_chk(OFF_SC1, 8'h57);
    idle(1400);
    pulse(6'h20);
    idle(900);
    chk(11'(mode_state), 11'(ST_WAKE));
    wait_mode(ST_SLEEP, 2000);
    chk(11'(cur_rate_sel), 11'h005);
    chk(11'(cur_os_mode), 11'h001);
    pulse(6'h03);
    u_host.wr(OFF_WAKE_SRC, 8'h00);
    pulse(6'h20);
    u_host.wr(OFF_WAKE_SRC, 8'h40);
    u_host.wr(OFF_IRQ_EN, 8'h9d);
    pulse(6'h20);
    chk(11'(mode_state), 11'(ST_SLEEP));
    chk(11'(func_enable), 11'h007);
    u_host.wr(OFF_IRQ_EN, 8'hbd);
    pulse(6'h20);
    chk(11'(mode_state), 11'(ST_WAKE));
    chk(11'(cur_rate_sel), 11'h002);
    idle(1);
    chk(11'(irq_cnt), 11'h002);
    u_host.wr(OFF_SC2, 8'h8a);
    u_host.wr(OFF_INACT, 8'h00);
    // 200 Hz is four base ticks of four cycles: ten strobes in 160 cycles
    ticks = 0;
    idle(160);
    chk(11'(ticks), 11'h00a);
    chk(11'(mode_state), 11'(ST_WAKE));
    u_host.wr(OFF_SC1, 8'h56);
    idle(1);
    chk(11'(mode_state), 11'(ST_STANDBY));
    u_host.wr(OFF_SC2, 8'h40);
    idle(1);
    chk(11'(boot_busy), 11'h001);
    chk(11'(serial_if_rst), 11'h001);
    for (int i = 0; i < 40 && boot_busy !== 1'b0; i++) @(negedge sys_clk);
    idle(2);
    rd_chk(OFF_SC1, RST_SC1);
    rd_chk(OFF_SC2, RST_SC2);
    chk(11'(self_test_en), 11'h000);
    // Slowest rate doubles the step length
    u_host.wr(OFF_SC1, 8'h38);
    u_host.wr(OFF_SC2, 8'h04);
    u_host.wr(OFF_INACT, 8'h01);
    u_host.wr(OFF_SC1, 8'h39);
    idle(2);
    chk(cur_os_ratio, 11'h080);
    idle(1700);
    chk(11'(mode_state), 11'(ST_WAKE));
    wait_mode(ST_SLEEP, 600);
    chk(cur_os_ratio, 11'h004);
    close_out();
  end
endmodule
`default_nettype wire
